// file: hw/timer8_pkg.sv
/*
  Shared constants and types for the 8-bit timer wave and mode control block:
  register offsets, field positions, reset values, mode and clock encodings.
  Assumes a single 8-bit register port driven by the core on core_clk.
*/
package timer8_pkg;

  // ****************************************
  // Register offsets (data space)
  // ****************************************
  localparam logic [7:0] OFS_FLAGS    = 8'h35;
  localparam logic [7:0] OFS_SYNC     = 8'h43;
  localparam logic [7:0] OFS_CTRL_A   = 8'h44;
  localparam logic [7:0] OFS_CTRL_B   = 8'h45;
  localparam logic [7:0] OFS_COUNT    = 8'h46;
  localparam logic [7:0] OFS_CMP_A    = 8'h47;
  localparam logic [7:0] OFS_CMP_B    = 8'h48;
  localparam logic [7:0] OFS_MASK     = 8'h6e;
  localparam logic [7:0] IO_OFFSET    = 8'h20;
  localparam logic [7:0] IO_SPAN      = 8'h40;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRLA_ACT_A_MSB = 7;
  localparam int CTRLA_ACT_B_MSB = 5;
  localparam int CTRLB_FORCE_A   = 7;
  localparam int CTRLB_FORCE_B   = 6;
  localparam int CTRLB_WAVE_HI   = 3;
  localparam int SYNC_HOLD       = 7;
  localparam int SYNC_RST_ASY    = 1;
  localparam int SYNC_RST_SYNC   = 0;
  localparam int FLAG_OVF        = 0;
  localparam int FLAG_CMP_A      = 1;
  localparam int FLAG_CMP_B      = 2;

  // ****************************************
  // Counter limits and prescaler divisors
  // ****************************************
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int DIV_8    = 8;
  localparam int DIV_64   = 64;
  localparam int DIV_256  = 256;
  localparam int DIV_1024 = 1024;

  typedef enum logic [2:0] {
    WM_NORMAL  = 3'h0,
    WM_PC_FF   = 3'h1,
    WM_CTC     = 3'h2,
    WM_FAST_FF = 3'h3,
    WM_RSVD_4  = 3'h4,
    WM_PC_A    = 3'h5,
    WM_RSVD_6  = 3'h6,
    WM_FAST_A  = 3'h7
  } waveMode_t;

  typedef enum logic [2:0] {
    CS_STOP     = 3'h0,
    CS_DIV1     = 3'h1,
    CS_DIV8     = 3'h2,
    CS_DIV64    = 3'h3,
    CS_DIV256   = 3'h4,
    CS_DIV1024  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clkSource_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic       ioSpace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_t;

endpackage : timer8_pkg

// file: hw/prescale_div.sv
/*
  Free-running prescaler giving one-cycle enables at clk/8, /64, /256, /1024.
  Assumes the caller holds clear high to reset the divider chain.
*/
`timescale 1ns/100ps
module prescale_div
  import timer8_pkg::*;
#(
  parameter int WIDTH = $clog2(DIV_1024)
) (
  input  wire logic       core_clk,  // Core clock
  input  wire logic       rst,       // Synchronous reset
  input  wire logic       clear,     // Hold divider at zero
  output logic      [3:0] tapTick    // Enables /8 /64 /256 /1024
);
  import timer8_pkg::*;

  logic [WIDTH-1:0] div_q;

  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ****************************************
  // One tap per divisor
  // ****************************************
  for (genvar t = 0; t < 4; t++) begin : g_tap
    localparam int BITS = (t == 0) ? $clog2(DIV_8) : (t == 1) ? $clog2(DIV_64) :
                          (t == 2) ? $clog2(DIV_256) : $clog2(DIV_1024);
    assign tapTick[t] = !clear && (&div_q[BITS-1:0]);
  end

endmodule : prescale_div

// file: hw/timer8_wave_mode_control.sv
/*
  Control part of an 8-bit timer/counter: mode decode, counting, buffered
  compare values, waveform outputs, forced compares, clock select, flags and
  interrupt requests. Assumes an 8-bit register port from the core, a pin
  interface that resolves drive enables, and an asynchronous count pin.
*/
`timescale 1ns/100ps
// Summary of operation
// - Phase-correct channel B: 10 clears up/sets down on match; 11 does the opposite.
// - Phase-correct channel B: 00 leaves pin to port; 01 reserved, no action.
// - In PWM modes, compare value equal TOP with upper action bit: skip match, act at TOP.
// - Three mode bits select normal, phase-correct, clear-on-match or fast modes.
// - Compare writes act at once in non-PWM, at TOP phase-correct, BOTTOM fast.
// - Overflow flag at MAX in 0,2,3; BOTTOM in phase-correct; TOP in 7.
// - Force strobe in non-PWM applies a match to that channel's output.
// - Forced match sets no flag and never clears the counter.
// - Force bits 7 and 6 are write strobes and read as zero.
// - Clock select 000 stops; 001-101 give divide by 1,8,64,256,1024.
// - Select 110 counts falling, 111 rising pin edges, after synchronising.
// - Pin edges count even when the pin is an output.
// - Mask bits 2,1,0 with flag and global enable request each interrupt.
// - Registers below 0x60 also answer at offset minus 0x20 in I/O space.
// - Nonzero action overrides port; driver enabled only with direction bit set.
// - Counter write blocks compare match on the next timer tick.
// - Flags clear on vector acknowledge or on writing one.
module timer8_wave_mode_control (
  input  wire logic              core_clk,     // Core clock, 20 MHz
  input  wire logic              rst,          // Synchronous reset, active high
  input  wire timer8_pkg::regReq_t regReq,     // Register access request
  output logic            [7:0]  readData,     // Read data, valid cycle after read
  input  wire logic              globalIrqEn,  // Global interrupt enable bit
  input  wire logic       [2:0]  irqAck,       // Vector executed: cmpB, cmpA, ovf
  output logic            [2:0]  irqReq,       // Interrupt requests: cmpB, cmpA, ovf
  input  wire logic              extCountPin,  // External count pin, asynchronous
  input  wire logic       [1:0]  dirBit,       // Direction bits for pins B, A
  output logic            [1:0]  compareOut,   // Compare output levels B, A
  output logic            [1:0]  cmpOverride,  // Compare output owns pin B, A
  output logic            [1:0]  compareDrvN   // Pin driver enable, low drives
);
  import timer8_pkg::*;

  // ****************************************
  // Register decode
  // ****************************************
  wire       addrOk  = !regReq.ioSpace || (regReq.addr < IO_SPAN);
  wire [7:0] effAddr = regReq.ioSpace ? regReq.addr + IO_OFFSET : regReq.addr;
  wire       hitFlags = addrOk && (effAddr == OFS_FLAGS);
  wire       hitSync  = addrOk && (effAddr == OFS_SYNC);
  wire       hitCtrlA = addrOk && (effAddr == OFS_CTRL_A);
  wire       hitCtrlB = addrOk && (effAddr == OFS_CTRL_B);
  wire       hitCount = addrOk && (effAddr == OFS_COUNT);
  wire       hitCmpA  = addrOk && (effAddr == OFS_CMP_A);
  wire       hitCmpB  = addrOk && (effAddr == OFS_CMP_B);
  wire       hitMask  = addrOk && (effAddr == OFS_MASK);
  wire       wrCtrlB  = regReq.wrEn && hitCtrlB;
  wire       wrCount  = regReq.wrEn && hitCount;
  wire [1:0] wrCmp    = {regReq.wrEn && hitCmpB, regReq.wrEn && hitCmpA};

  logic [7:0] ctrlA_q;
  logic [3:0] ctrlB_q;
  logic [2:0] mask_q;
  logic [2:0] flags_q;
  logic [7:0] count_q;
  logic [7:0] cmpBuf_q [2];
  logic [7:0] cmpAct_q [2];
  logic       dirDown_q;
  logic       blockMatch_q;
  logic       holdSync_q;
  logic       rstSync_q;
  logic       rstAsy_q;
  logic       extSync1_q;
  logic       extSync2_q;
  logic       extLast_q;
  logic [7:0] readData_q;
  logic [1:0] level_q;

  // ****************************************
  // Mode decode
  // ****************************************
  wire waveMode_t mode   = waveMode_t'({ctrlB_q[CTRLB_WAVE_HI], ctrlA_q[1:0]});
  wire        isPc       = (mode == WM_PC_FF) || (mode == WM_PC_A);
  wire        isFast     = (mode == WM_FAST_FF) || (mode == WM_FAST_A);
  wire        isPwm      = isPc || isFast;
  wire        topIsA     = (mode == WM_CTC) || (mode == WM_PC_A) || (mode == WM_FAST_A);
  wire  [7:0] topVal     = topIsA ? cmpAct_q[0] : COUNT_MAX;
  wire        atTop      = (count_q == topVal);
  wire        atBottom   = (count_q == COUNT_BOTTOM);
  wire        atMax      = (count_q == COUNT_MAX);
  wire clkSource_t clkSel = clkSource_t'(ctrlB_q[2:0]);
  wire  [1:0] cmpActionA = ctrlA_q[CTRLA_ACT_A_MSB -: 2];
  wire  [1:0] cmpActionB = ctrlA_q[CTRLA_ACT_B_MSB -: 2];

  // ****************************************
  // Clock select
  // ****************************************
  logic [3:0] tapTick;

  prescale_div #(
    .WIDTH ($clog2(DIV_1024))
  ) u_prescale (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (rstSync_q),
    .tapTick  (tapTick)
  );

  // Pin edges are taken whatever the pin direction, so software can count
  wire extRise   = extSync2_q && !extLast_q;
  wire extFall   = !extSync2_q && extLast_q;
  wire intTick   = !rstSync_q && (clkSel == CS_DIV1);
  wire timerTick = intTick
                || ((clkSel == CS_DIV8)     && tapTick[0])
                || ((clkSel == CS_DIV64)    && tapTick[1])
                || ((clkSel == CS_DIV256)   && tapTick[2])
                || ((clkSel == CS_DIV1024)  && tapTick[3])
                || ((clkSel == CS_EXT_FALL) && extFall)
                || ((clkSel == CS_EXT_RISE) && extRise);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extLast_q  <= 1'b0;
    end else begin
      extSync1_q <= extCountPin;
      extSync2_q <= extSync1_q;
      extLast_q  <= extSync2_q;
    end
  end

  // ****************************************
  // Counter and events
  // ****************************************
  wire       wrapUp   = ((mode == WM_CTC) || isFast) ? atTop : atMax;
  wire       turnDown = isPc && !dirDown_q && atTop;
  wire       turnUp   = isPc && dirDown_q && atBottom;
  wire [7:0] countInc = wrapUp ? COUNT_BOTTOM : count_q + 8'h01;
  wire [7:0] countPc  = (turnDown || (dirDown_q && !turnUp)) ? count_q - 8'h01
                                                             : count_q + 8'h01;
  wire [7:0] countNext = isPc ? countPc : countInc;
  // PWM update point: turn at TOP in phase-correct, wrap to BOTTOM in fast
  wire       updNow   = timerTick && atTop && (isFast || !dirDown_q);
  wire       ovfEvent = timerTick && (isPc ? (dirDown_q && atBottom)
                                  : (mode == WM_FAST_A) ? atTop : atMax);
  logic [1:0] cmpMatch;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q      <= RESET_BYTE;
      dirDown_q    <= 1'b0;
      blockMatch_q <= 1'b0;
    end else if (wrCount) begin
      count_q      <= regReq.wdata;
      blockMatch_q <= 1'b1;
    end else if (timerTick) begin
      count_q      <= countNext;
      blockMatch_q <= 1'b0;
      if (!isPc) begin
        dirDown_q <= 1'b0;
      end else if (turnDown) begin
        dirDown_q <= 1'b1;
      end else if (turnUp) begin
        dirDown_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Compare channels, index 0 is A, 1 is B
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_chan
    wire [1:0] act     = (i == 0) ? cmpActionA : cmpActionB;
    wire       force_  = wrCtrlB && !isPwm && regReq.wdata[CTRLB_FORCE_A - i];
    wire       special = act[1] && (cmpAct_q[i] == topVal);
    // Channel B code 01 is reserved in PWM; A toggles only with the high mode bit
    wire       keep01  = (act == 2'b01) && !((i == 0) && ctrlB_q[CTRLB_WAVE_HI]);
    wire [1:0] pwmAct  = keep01 ? 2'b00 : act;
    logic      lvl_d;

    assign cmpMatch[i] = timerTick && !blockMatch_q && (count_q == cmpAct_q[i]);

    function automatic logic applyAct(input logic [1:0] c, input logic up, input logic cur);
      case (c)
        2'b01:   applyAct = !cur;
        2'b10:   applyAct = !up;
        2'b11:   applyAct = up;
        default: applyAct = cur;
      endcase
    endfunction : applyAct

    always_comb begin
      lvl_d = level_q[i];
      if (!isPwm) begin
        if (cmpMatch[i] || force_) begin
          lvl_d = applyAct(act, 1'b1, level_q[i]);
        end
      end else if (isFast) begin
        if (cmpMatch[i] && !special) begin
          lvl_d = applyAct(pwmAct, 1'b1, level_q[i]);
        end
        if (timerTick && atTop && pwmAct[1]) begin
          lvl_d = applyAct(pwmAct, 1'b0, level_q[i]);
        end
      end else begin
        if (cmpMatch[i] && !special) begin
          lvl_d = applyAct(pwmAct, !dirDown_q, level_q[i]);
        end else if (special && timerTick && atTop && !dirDown_q) begin
          lvl_d = applyAct(pwmAct, 1'b1, level_q[i]);
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        cmpBuf_q[i] <= RESET_BYTE;
        cmpAct_q[i] <= RESET_BYTE;
        level_q[i]  <= 1'b0;
      end else begin
        level_q[i] <= lvl_d;
        if (wrCmp[i]) begin
          cmpBuf_q[i] <= regReq.wdata;
        end
        if (!isPwm) begin
          cmpAct_q[i] <= wrCmp[i] ? regReq.wdata : cmpBuf_q[i];
        end else if (updNow) begin
          cmpAct_q[i] <= cmpBuf_q[i];
        end
      end
    end

    assign compareOut[i]  = level_q[i];
    assign cmpOverride[i] = (act != 2'b00);
    assign compareDrvN[i] = !((act != 2'b00) && dirBit[i]);
  end

  // ****************************************
  // Flags and interrupt requests
  // ****************************************
  // A forced match never reaches the set term
  wire [2:0] flagSet = {cmpMatch[1], cmpMatch[0], ovfEvent};
  wire [2:0] flagClr = irqAck | ({3{regReq.wrEn && hitFlags}} & regReq.wdata[2:0]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~flagClr) | flagSet;  // Set wins over clear
    end
  end

  assign irqReq = flags_q & mask_q & {3{globalIrqEn}};

  // ****************************************
  // Control registers and read path
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlA_q    <= RESET_BYTE;
      ctrlB_q    <= 4'h0;
      mask_q     <= 3'h0;
      holdSync_q <= 1'b0;
      rstSync_q  <= 1'b0;
      rstAsy_q   <= 1'b0;
    end else begin
      if (regReq.wrEn && hitCtrlA) begin
        ctrlA_q <= {regReq.wdata[7:4], 2'b00, regReq.wdata[1:0]};
      end
      if (wrCtrlB) begin
        ctrlB_q <= regReq.wdata[3:0];  // Force bits are strobes, never stored
      end
      if (regReq.wrEn && hitMask) begin
        mask_q <= regReq.wdata[2:0];
      end
      // Prescaler resets self-clear unless hold mode keeps them asserted
      if (regReq.wrEn && hitSync) begin
        holdSync_q <= regReq.wdata[SYNC_HOLD];
        rstSync_q  <= regReq.wdata[SYNC_RST_SYNC];
        rstAsy_q   <= regReq.wdata[SYNC_RST_ASY];
      end else if (!holdSync_q) begin
        rstSync_q <= 1'b0;
        rstAsy_q  <= 1'b0;
      end
    end
  end

  wire [7:0] readSel =
      hitFlags ? {5'h00, flags_q} :
      hitSync  ? {holdSync_q, 5'h00, rstAsy_q, rstSync_q} :
      hitCtrlA ? ctrlA_q :
      hitCtrlB ? {4'h0, ctrlB_q} :
      hitCount ? count_q :
      hitCmpA  ? cmpBuf_q[0] :
      hitCmpB  ? cmpBuf_q[1] :
      hitMask  ? {5'h00, mask_q} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readData_q <= RESET_BYTE;
    end else begin
      readData_q <= regReq.rdEn ? readSel : 8'h00;
    end
  end

  assign readData = readData_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_force_read_zero;
    @(posedge core_clk) disable iff (rst)
    (regReq.rdEn && hitCtrlB) |=> (readData[7:6] == 2'b00);
  endproperty
  a_force_read_zero: assert property (p_force_read_zero) else $error("force bits read one");

  property p_stop_holds;
    @(posedge core_clk) disable iff (rst)
    (clkSel == CS_STOP && !wrCount) |=> $stable(count_q);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

  property p_force_no_flag;
    @(posedge core_clk) disable iff (rst)
    (g_chan[0].force_ && !cmpMatch[0] && !flags_q[FLAG_CMP_A]) |=> !flags_q[FLAG_CMP_A];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

  property p_irq_cause;
    @(posedge core_clk) disable iff (rst)
    $rose(irqReq[FLAG_OVF]) |-> (globalIrqEn && mask_q[FLAG_OVF] && flags_q[FLAG_OVF]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("overflow request without cause");

  property p_write_blocks;
    @(posedge core_clk) disable iff (rst)
    (wrCount ##1 timerTick) |-> (cmpMatch == 2'b00);
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match after count write");

  property p_ovf_normal;
    @(posedge core_clk) disable iff (rst)
    (timerTick && mode == WM_NORMAL && count_q == 8'hff && !wrCount) |=> flags_q[FLAG_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("no overflow at max");

  property p_fast_hold_cmp;
    @(posedge core_clk) disable iff (rst)
    (isFast && !updNow) |=> $stable(cmpAct_q[0]);
  endproperty
  a_fast_hold_cmp: assert property (p_fast_hold_cmp) else $error("fast compare moved early");

  property p_pc_b_clear_up;
    @(posedge core_clk) disable iff (rst)
    (isPc && cmpActionB == 2'b10 && cmpMatch[1] && !dirDown_q && cmpAct_q[1] != topVal)
      |=> !compareOut[1];
  endproperty
  a_pc_b_clear_up: assert property (p_pc_b_clear_up) else $error("B not cleared on up match");

  property p_ext_rise_count;
    @(posedge core_clk) disable iff (rst)
    (clkSel == CS_EXT_RISE && extRise && mode == WM_NORMAL && !wrCount)
      |=> (count_q == 8'($past(count_q) + 8'h01));
  endproperty
  a_ext_rise_count: assert property (p_ext_rise_count) else $error("pin edge not counted");

  property p_io_alias;
    @(posedge core_clk) disable iff (rst)
    (regReq.wrEn && regReq.ioSpace && regReq.addr == 8'h25)
      |=> (ctrlB_q == $past(regReq.wdata[3:0]));
  endproperty
  a_io_alias: assert property (p_io_alias) else $error("I/O alias write lost");

  property p_force_toggle;
    @(posedge core_clk) disable iff (rst)
    (g_chan[0].force_ && !cmpMatch[0] && cmpActionA == 2'b01)
      |=> (compareOut[0] != $past(compareOut[0]));
  endproperty
  a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle");

  property p_ack_clears;
    @(posedge core_clk) disable iff (rst)
    (irqAck[FLAG_OVF] && !ovfEvent) |=> !flags_q[FLAG_OVF];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack left flag set");

  c_pc_turn:  cover property (@(posedge core_clk) disable iff (rst) isPc && turnDown && timerTick);
  c_ctc_wrap: cover property (@(posedge core_clk) disable iff (rst)
                              mode == WM_CTC && timerTick && atTop);
  c_irq_cmpb: cover property (@(posedge core_clk) disable iff (rst) irqReq[FLAG_CMP_B]);

endmodule : timer8_wave_mode_control

// file: verif/count_pin_model.sv
/*
  Software-driven count pin: on go it gives a burst of full pulses.
  Assumes core_clk is the timer clock; the pin rests low between bursts.
*/
`timescale 1ns/100ps
module count_pin_model (
  input  wire logic       core_clk,     // Core clock
  input  wire logic       rst,          // Synchronous reset
  input  wire logic       go,           // Start a burst
  input  wire logic [7:0] pulses,       // Pulses in the burst
  output logic            extCountPin,  // Pin level to the timer
  output logic            busy          // Burst in progress
);
  // ****************************************
  // Pulse generator
  // ****************************************
  logic [7:0] left_q;
  logic [2:0] phase_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      left_q  <= 8'h00;
      phase_q <= 3'h0;
    end else if (go) begin
      left_q  <= pulses;
      phase_q <= 3'h0;
    end else if (left_q != 8'h00) begin
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7) left_q <= left_q - 8'h01;
    end
  end

  // Four cycles high then four low: slow enough for the synchroniser
  assign extCountPin = (left_q != 8'h00) && !phase_q[2];
  assign busy        = (left_q != 8'h00);
endmodule : count_pin_model

// file: verif/tb_timer8_wave_mode_control.sv
/*
  Self-checking bench for the timer wave and mode control block.
  Assumes the package, design files and count pin model are compiled first.
*/
`timescale 1ns/100ps
module tb_timer8_wave_mode_control;
  import timer8_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  regReq_t     regReq      = '0;
  logic        globalIrqEn = 1'b0;
  logic [2:0]  irqAck      = 3'h0;
  logic [1:0]  dirBit      = 2'h0;
  logic        go          = 1'b0;
  logic [7:0]  pulses      = 8'h00;
  logic        extCountPin, busy;
  logic [7:0]  readData, d, v;
  logic [2:0]  irqReq;
  logic [1:0]  compareOut, cmpOverride, compareDrvN;
  logic [15:0] hi;
  int          err_total   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          n;
  logic [7:0]  regs [5] = '{OFS_SYNC, OFS_CTRL_A, OFS_CTRL_B, OFS_MASK, 8'h50};
  logic [1:0]  acts [4] = '{2'b01, 2'b01, 2'b11, 2'b10};
  logic [1:0]  pcAct [3] = '{2'b10, 2'b11, 2'b00};

  timer8_wave_mode_control timer8_wave_mode_control_i (.core_clk(core_clk), .rst(rst),
    .regReq(regReq), .readData(readData), .globalIrqEn(globalIrqEn), .irqAck(irqAck),
    .irqReq(irqReq), .extCountPin(extCountPin), .dirBit(dirBit), .compareOut(compareOut),
    .cmpOverride(cmpOverride), .compareDrvN(compareDrvN));
  count_pin_model count_pin_model_i (.core_clk(core_clk), .rst(rst), .go(go),
    .pulses(pulses), .extCountPin(extCountPin), .busy(busy));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      $display("unexpected at %0t: run timed out", $time);
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic tick();
    @(posedge core_clk);
    #5;
  endtask : tick
  task automatic wr(logic io, logic [7:0] a, logic [7:0] dat);
    tick();
    regReq = '{1'b1, 1'b0, io, a, dat};
    tick();
    regReq.wrEn = 1'b0;
  endtask : wr
  task automatic rd(logic io, logic [7:0] a, output logic [7:0] dat);
    tick();
    regReq = '{1'b0, 1'b1, io, a, 8'h00};
    tick();
    dat = readData;
    regReq.rdEn = 1'b0;
  endtask : rd
  task automatic cmp(logic [7:0] got, logic [7:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic near(logic [15:0] got, int exp, int tol, string what);
    int df;
    df = int'(got) - exp;
    checks_done++;
    if ((^got === 1'bx) || df > tol || df < -tol) begin
      err_total++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : near
  function automatic int expCount(int c, int w);
    int dv [6] = '{0, 1, DIV_8, DIV_64, DIV_256, DIV_1024};
    return (c == 0) ? 0 : (w / dv[c]) % 256;
  endfunction : expCount
  function automatic int pcHigh(logic [1:0] a, int c);
    return (a == 2'b10) ? 2 * c : 510 - 2 * c;
  endfunction : pcHigh

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(91625));
    repeat (12) @(posedge core_clk);
    #5 rst = 1'b0;
    foreach (regs[i]) begin
      rd(1'b0, regs[i], d);
      cmp(d, 8'h00, "reset or unmapped read");
    end
    v = 8'($urandom_range(1, 7));
    wr(1'b0, OFS_MASK, v);
    rd(1'b0, OFS_MASK, d);
    cmp(d, v, "mask");
    wr(1'b1, OFS_CMP_A - IO_OFFSET, ~v);
    rd(1'b0, OFS_CMP_A, d);
    cmp(d, ~v, "io alias");
    dirBit = 2'h1;
    foreach (acts[i]) begin
      wr(1'b0, OFS_CTRL_A, {acts[i], 6'h00});
      wr(1'b1, 8'h25, 8'h80);
      tick();
      cmp({7'h00, compareOut[0]}, {7'h00, ~i[0]}, "forced output");
    end
    cmp({4'h0, cmpOverride, compareDrvN}, 8'h06, "pin ownership");
    rd(1'b0, OFS_CTRL_B, d);
    cmp(d, 8'h00, "force bits read");
    rd(1'b0, OFS_FLAGS, d);
    cmp(d, 8'h00, "forced flags");
    dirBit = 2'h0;
    tick();
    cmp({6'h00, compareDrvN}, 8'h03, "driver off");
    wr(1'b0, OFS_CTRL_A, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(1'b0, OFS_COUNT, 8'h00);
      wr(1'b0, OFS_CTRL_B, 8'(c));
      if (c < 6) begin
        repeat (2100) tick();
        rd(1'b0, OFS_COUNT, d);
        near({8'h00, d}, expCount(c, 2100), 3, "prescaled count");
      end else begin
        n = $urandom_range(1, 40);
        pulses = 8'(n);
        go = 1'b1;
        tick();
        go = 1'b0;
        repeat (8 * n + 8) tick();
        cmp({7'h00, busy}, 8'h00, "burst finished");
        rd(1'b0, OFS_COUNT, d);
        cmp(d, 8'(n), "pin edges");
      end
      wr(1'b0, OFS_CTRL_B, 8'h00);
    end
    wr(1'b0, OFS_MASK, 8'h01);
    for (int k = 0; k < 2; k++) begin
      globalIrqEn = 1'b1;
      wr(1'b0, OFS_FLAGS, 8'h07);
      cmp({5'h00, irqReq}, 8'h00, "request before overflow");
      wr(1'b0, OFS_COUNT, 8'hf0);
      wr(1'b0, OFS_CTRL_B, 8'h01);
      repeat (20) tick();
      wr(1'b0, OFS_CTRL_B, 8'h00);
      cmp({5'h00, irqReq}, 8'h01, "overflow request");
      globalIrqEn = 1'(k);
      tick();
      cmp({5'h00, irqReq}, {7'h00, 1'(k)}, "global enable");
      if (k == 0) begin
        irqAck = 3'h1;
        tick();
        irqAck = 3'h0;
      end else wr(1'b0, OFS_FLAGS, 8'h01);
      tick();
      rd(1'b0, OFS_FLAGS, d);
      cmp(d & 8'h01, 8'h00, "flag cleared");
    end
    foreach (pcAct[i]) begin
      n = $urandom_range(16, 240);
      wr(1'b0, OFS_CMP_B, 8'(n));
      wr(1'b0, OFS_CTRL_A, {2'b00, pcAct[i], 4'h1});
      wr(1'b0, OFS_CTRL_B, 8'h01);  // Force bits kept zero in PWM
      repeat (520) tick();
      hi = 16'h0000;
      repeat (510) begin
        tick();
        hi += compareOut[1];
      end
      wr(1'b0, OFS_CTRL_B, 8'h00);
      if (pcAct[i] != 2'b00) near(hi, pcHigh(pcAct[i], n), 3, "pwm duty");
      else cmp({6'h00, cmpOverride}, 8'h00, "disconnected");
    end
    conclude();
  end
endmodule : tb_timer8_wave_mode_control
